/* File: hdl/iegt_pkg.sv */
// Constants and types for the interrupt enable gating block
package iegt_pkg;
  localparam int IEGT_NSRC = 17;
  localparam int IEGT_AW = 12;
  // Printed register offsets are indices; byte address is four times the index
  localparam logic [IEGT_AW-1:0] IEGT_IDX_EXT = 12'h09b;
  localparam logic [IEGT_AW-1:0] IEGT_IDX_EXT2 = 12'h09c;
  localparam logic [IEGT_AW-1:0] IEGT_IDX_MAIN = 12'h0a8;
  localparam logic [IEGT_AW-1:0] IEGT_IDX_SWSET = 12'h0a0;
  localparam logic [IEGT_AW-1:0] IEGT_IDX_RAW = 12'h0a1;
  localparam logic [IEGT_AW-1:0] IEGT_IDX_REQ = 12'h0a2;
  localparam logic [7:0] IEGT_RST_EN = 8'h00;
  localparam logic [7:0] IEGT_MASK_MAIN = 8'hff;
  localparam logic [7:0] IEGT_MASK_EXT = 8'hbf;
  localparam logic [7:0] IEGT_MASK_EXT2 = 8'h07;
  // Bit positions in the enable registers
  localparam int IEGT_B_GLOBAL = 7;
  localparam int IEGT_B_ADC = 6;
  localparam int IEGT_B_BOD = 5;
  localparam int IEGT_B_UART0 = 4;
  localparam int IEGT_B_TMR1 = 3;
  localparam int IEGT_B_EXT1 = 2;
  localparam int IEGT_B_TMR0 = 1;
  localparam int IEGT_B_EXT0 = 0;
  localparam int IEGT_B_T2D = 7;
  localparam int IEGT_B_T2C = 5;
  localparam int IEGT_B_WDT = 4;
  localparam int IEGT_B_T2B = 3;
  localparam int IEGT_B_T2A = 2;
  localparam int IEGT_B_PIN = 1;
  localparam int IEGT_B_I2C = 0;
  localparam int IEGT_B_WKT = 2;
  localparam int IEGT_B_TMR3 = 1;
  localparam int IEGT_B_UART1 = 0;
  // Source index in the request vector, in vector order
  typedef enum logic [4:0] {
    IEGT_S_EXT0 = 5'h00, IEGT_S_TMR0 = 5'h01, IEGT_S_EXT1 = 5'h02,
    IEGT_S_TMR1 = 5'h03, IEGT_S_UART0 = 5'h04, IEGT_S_T2A = 5'h05,
    IEGT_S_I2C = 5'h06, IEGT_S_PIN = 5'h07, IEGT_S_BOD = 5'h08,
    IEGT_S_WDT = 5'h09, IEGT_S_ADC = 5'h0a, IEGT_S_T2B = 5'h0b,
    IEGT_S_T2C = 5'h0c, IEGT_S_T2D = 5'h0d, IEGT_S_UART1 = 5'h0e,
    IEGT_S_TMR3 = 5'h0f, IEGT_S_WKT = 5'h10
  } iegt_src_t;
  // Flag conditions arriving from the peripherals and pins
  typedef struct packed {
    logic ext_irq0_pin;
    logic ext_irq1_pin;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer3_overflow_flag;
    logic uart0_transmit_flag;
    logic uart0_receive_flag;
    logic uart1_transmit_flag;
    logic uart1_receive_flag;
    logic timer2a_flag;
    logic timer2b_flag;
    logic timer2c_flag;
    logic timer2d_flag;
    logic i2c_state_flag;
    logic i2c_timeout_flag;
    logic [7:0] pin_flag_bank;
    logic brownout_flag;
    logic watchdog_flag;
    logic adc_done_flag;
    logic wakeup_timer_flag;
  } iegt_flags_t;
endpackage

/* File: hdl/iegt_top.sv */
// Interrupt enable gating with APB register slave
`timescale 1ns/1ps
module iegt_top
  import iegt_pkg::*;
#(
  parameter int NSRC = IEGT_NSRC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iegt_flags_t flags,
  output logic [NSRC-1:0] irq_req,
  output logic irq_any
);

  // Enable registers and software request register
  logic [7:0] main_reg;
  logic [7:0] ext_reg;
  logic [7:0] ext2_reg;
  logic [NSRC-1:0] swset_reg;

  // Bus response registers
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Gated request registers toward the CPU
  logic [NSRC-1:0] irq_req_reg;
  logic irq_any_reg;

  // Combinational views
  logic [NSRC-1:0] hw_flag;
  logic [NSRC-1:0] raw_flag;
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] irq_req_next;
  logic [IEGT_AW-1:0] reg_idx;
  logic addr_ok;
  logic [31:0] rd_word;
  logic setup_ph;
  logic wr_go;

  // Word index from byte address; low two bits must be zero
  assign reg_idx = paddr[IEGT_AW+1:2];
  assign setup_ph = psel && !penable;
  assign wr_go = psel && penable && pready_reg && pwrite && pstrb[0];

  // Hardware flag conditions in vector order; shared sources are ORed
  always_comb begin
    hw_flag = '0;
    hw_flag[IEGT_S_EXT0] = flags.ext_irq0_pin;
    hw_flag[IEGT_S_TMR0] = flags.timer0_overflow_flag;
    hw_flag[IEGT_S_EXT1] = flags.ext_irq1_pin;
    hw_flag[IEGT_S_TMR1] = flags.timer1_overflow_flag;
    hw_flag[IEGT_S_UART0] = flags.uart0_transmit_flag | flags.uart0_receive_flag;
    hw_flag[IEGT_S_T2A] = flags.timer2a_flag;
    hw_flag[IEGT_S_I2C] = flags.i2c_state_flag | flags.i2c_timeout_flag;
    hw_flag[IEGT_S_PIN] = |flags.pin_flag_bank;
    hw_flag[IEGT_S_BOD] = flags.brownout_flag;
    hw_flag[IEGT_S_WDT] = flags.watchdog_flag;
    hw_flag[IEGT_S_ADC] = flags.adc_done_flag;
    hw_flag[IEGT_S_T2B] = flags.timer2b_flag;
    hw_flag[IEGT_S_T2C] = flags.timer2c_flag;
    hw_flag[IEGT_S_T2D] = flags.timer2d_flag;
    hw_flag[IEGT_S_UART1] = flags.uart1_transmit_flag | flags.uart1_receive_flag;
    hw_flag[IEGT_S_TMR3] = flags.timer3_overflow_flag;
    hw_flag[IEGT_S_WKT] = flags.wakeup_timer_flag;
  end

  // Software requests share the same gating path as hardware ones
  assign raw_flag = hw_flag | swset_reg;

  // Individual enables gathered into vector order
  always_comb begin
    src_en = '0;
    src_en[IEGT_S_EXT0] = main_reg[IEGT_B_EXT0];
    src_en[IEGT_S_TMR0] = main_reg[IEGT_B_TMR0];
    src_en[IEGT_S_EXT1] = main_reg[IEGT_B_EXT1];
    src_en[IEGT_S_TMR1] = main_reg[IEGT_B_TMR1];
    src_en[IEGT_S_UART0] = main_reg[IEGT_B_UART0];
    src_en[IEGT_S_BOD] = main_reg[IEGT_B_BOD];
    src_en[IEGT_S_ADC] = main_reg[IEGT_B_ADC];
    src_en[IEGT_S_I2C] = ext_reg[IEGT_B_I2C];
    src_en[IEGT_S_PIN] = ext_reg[IEGT_B_PIN];
    src_en[IEGT_S_T2A] = ext_reg[IEGT_B_T2A];
    src_en[IEGT_S_T2B] = ext_reg[IEGT_B_T2B];
    src_en[IEGT_S_WDT] = ext_reg[IEGT_B_WDT];
    src_en[IEGT_S_T2C] = ext_reg[IEGT_B_T2C];
    src_en[IEGT_S_T2D] = ext_reg[IEGT_B_T2D];
    src_en[IEGT_S_UART1] = ext2_reg[IEGT_B_UART1];
    src_en[IEGT_S_TMR3] = ext2_reg[IEGT_B_TMR3];
    src_en[IEGT_S_WKT] = ext2_reg[IEGT_B_WKT];
  end

  // Flags are not consumed here, so a blocked flag stays pending
  // and reappears as soon as the global enable returns
  assign irq_req_next = raw_flag & src_en & {NSRC{main_reg[IEGT_B_GLOBAL]}};

  // Main enable register, all bits writable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_reg <= IEGT_RST_EN;
    end else if (wr_go && addr_ok && reg_idx == IEGT_IDX_MAIN) begin
      main_reg <= pwdata[7:0] & IEGT_MASK_MAIN;
    end
  end

  // First extended register; reserved bit 6 never stores
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_reg <= IEGT_RST_EN;
    end else if (wr_go && addr_ok && reg_idx == IEGT_IDX_EXT) begin
      ext_reg <= pwdata[7:0] & IEGT_MASK_EXT;
    end
  end

  // Second extended register; bits 7 to 3 never store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext2_reg <= IEGT_RST_EN;
    end else if (wr_go && addr_ok && reg_idx == IEGT_IDX_EXT2) begin
      ext2_reg <= pwdata[7:0] & IEGT_MASK_EXT2;
    end
  end

  // Software request bits: write one to raise, zero to withdraw
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swset_reg <= '0;
    end else if (wr_go && addr_ok && reg_idx == IEGT_IDX_SWSET) begin
      swset_reg <= pwdata[NSRC-1:0];
    end
  end

  // Address decode for the six mapped words
  always_comb begin
    addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:IEGT_AW+2] == '0);
    rd_word = '0;
    if (reg_idx == IEGT_IDX_MAIN) begin
      rd_word[7:0] = main_reg;
    end else if (reg_idx == IEGT_IDX_EXT) begin
      rd_word[7:0] = ext_reg;
    end else if (reg_idx == IEGT_IDX_EXT2) begin
      rd_word[7:0] = ext2_reg;
    end else if (reg_idx == IEGT_IDX_SWSET) begin
      rd_word[NSRC-1:0] = swset_reg;
    end else if (reg_idx == IEGT_IDX_RAW) begin
      rd_word[NSRC-1:0] = raw_flag;
    end else if (reg_idx == IEGT_IDX_REQ) begin
      rd_word[NSRC-1:0] = irq_req_reg;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Slave answers in the first access cycle; response is prepared
  // during setup so every bus output comes straight from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (setup_ph) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !addr_ok;
      prdata_reg <= (addr_ok && !pwrite) ? rd_word : '0;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end
  end

  // Requests to the CPU, one cycle behind the gating terms
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req_reg <= '0;
      irq_any_reg <= 1'b0;
    end else begin
      irq_req_reg <= irq_req_next;
      irq_any_reg <= |irq_req_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_req = irq_req_reg;
  assign irq_any = irq_any_reg;

endmodule // iegt_top

/* File: verif/iegt_props.sv */
// Concurrent checks on the enable gating block ports
`timescale 1ns/1ps
module iegt_props
  import iegt_pkg::*;
#(
  parameter int NSRC = IEGT_NSRC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire iegt_flags_t flags,
  input wire logic [NSRC-1:0] irq_req,
  input wire logic irq_any
);
  logic [7:0] main_reg;
  // Shadow of the main enable word, so gating checks need no peek inside
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_reg <= 8'h00;
    end else if (psel && penable && pready && pwrite && pstrb[0] && paddr == 32'h0000_02a0) begin
      main_reg <= pwdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  AST_PREADY_NEXT: assert property (s_setup |=> pready) else $error("no answer after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
  AST_GLOBAL_OFF: assert property (!main_reg[7] |=> irq_req == '0) else $error("request with global off");
  AST_ANY: assert property (irq_any == (|irq_req)) else $error("summary mismatch");
  AST_EXT0_PASS: assert property (main_reg[7] && main_reg[0] && flags.ext_irq0_pin
    |=> irq_req[IEGT_S_EXT0]) else $error("ext0 not passed");
  AST_ADC_MASK: assert property (!main_reg[6] |=> !irq_req[IEGT_S_ADC]) else $error("adc not masked");
  AST_UART0_PASS: assert property (main_reg[7] && main_reg[4]
    && (flags.uart0_transmit_flag || flags.uart0_receive_flag) |=> irq_req[IEGT_S_UART0]) else $error("uart0 lost");
  AST_BOD_PASS: assert property (main_reg[7] && main_reg[5] && flags.brownout_flag
    |=> irq_req[IEGT_S_BOD]) else $error("brownout lost");
endmodule // iegt_props
bind iegt_top iegt_props #(.NSRC(NSRC)) u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .flags(flags),
  .irq_req(irq_req), .irq_any(irq_any));

/* File: verif/iegt_cpu_model.sv */
// Behavioural CPU side that takes the lowest numbered pending request
`timescale 1ns/1ps
module iegt_cpu_model
  import iegt_pkg::*;
#(
  parameter int NSRC = IEGT_NSRC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NSRC-1:0] irq_req,
  input wire logic irq_any,
  output logic [4:0] taken_src,
  output logic taken_valid
);
  // No priority levels here; natural order is enough to consume requests
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      taken_valid <= 1'b0;
      taken_src <= 5'h00;
    end else begin
      taken_valid <= irq_any;
      for (int i = NSRC - 1; i >= 0; i--) begin
        if (irq_req[i]) taken_src <= 5'(i);
      end
    end
  end
endmodule // iegt_cpu_model

/* File: verif/iegt_bench.sv */
// Self-checking bench for the interrupt enable gating block
`timescale 1ns/1ps
module interrupt_enable_gating_bench;
  import iegt_pkg::*;
  typedef struct {logic [31:0] a; logic [7:0] en; int fp; int src;} iegt_row_t;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_any, taken_valid, er;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'h1;
  logic [26:0] fv;
  iegt_flags_t flags = '0;
  logic [16:0] irq_req;
  logic [4:0] taken_src;
  int fail_count = 0, n_checks = 0;
  // Enable word, enable bits, flag bit position, request index
  iegt_row_t rows[21] = '{'{32'h2a0, 8'h81, 26, 0}, '{32'h2a0, 8'h82, 24, 1}, '{32'h2a0, 8'h84, 25, 2},
    '{32'h2a0, 8'h88, 23, 3}, '{32'h2a0, 8'h90, 21, 4}, '{32'h2a0, 8'h90, 20, 4}, '{32'h2a0, 8'ha0, 3, 8},
    '{32'h2a0, 8'hc0, 1, 10}, '{32'h26c, 8'h04, 17, 5}, '{32'h26c, 8'h01, 13, 6}, '{32'h26c, 8'h01, 12, 6},
    '{32'h26c, 8'h02, 11, 7}, '{32'h26c, 8'h02, 4, 7}, '{32'h26c, 8'h10, 2, 9}, '{32'h26c, 8'h08, 16, 11},
    '{32'h26c, 8'h20, 15, 12}, '{32'h26c, 8'h80, 14, 13}, '{32'h270, 8'h01, 19, 14}, '{32'h270, 8'h01, 18, 14},
    '{32'h270, 8'h02, 22, 15}, '{32'h270, 8'h04, 0, 16}};
  iegt_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags(flags),
    .irq_req(irq_req), .irq_any(irq_any));
  iegt_cpu_model cpu (.clk(clk), .rst(rst), .irq_req(irq_req), .irq_any(irq_any), .taken_src(taken_src),
    .taken_valid(taken_valid));
  always #5 clk = ~clk;
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; the answer is taken at the edge that sees pready
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) fail_count++;
    rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  task settle;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      check("reset value", rd, 0);
      check("no error", er, 0);
    end
    apb(1, 32'h2a0, 32'h80);
    foreach (rows[i]) begin
      fv = '0; fv[rows[i].fp] = 1'b1; flags <= iegt_flags_t'(fv);
      apb(1, rows[i].a, {24'h0, rows[i].en}); settle;
      check("req on", irq_req, 17'h1 << rows[i].src);
      check("any", irq_any, 1);
      // Partner needs one more edge to consume the request it now sees
      @(posedge clk);
      check("cpu src", taken_src, rows[i].src);
      check("cpu valid", taken_valid, 1);
      apb(1, rows[i].a, (rows[i].a == 32'h2a0) ? 32'h80 : 32'h0); settle;
      check("req off", irq_req, 0);
      check("any off", irq_any, 0);
    end
    $display("per source gating done");
    apb(1, 32'h26c, 32'hff); apb(0, 32'h26c, 0); check("ext word", rd, 32'hbf);
    apb(1, 32'h270, 32'hff); apb(0, 32'h270, 0); check("ext2 word", rd, 32'h07);
    flags <= '0; apb(1, 32'h2a0, 32'h7f); fv = '0; fv[26] = 1'b1; flags <= iegt_flags_t'(fv); settle;
    check("global off", irq_req, 0);
    apb(1, 32'h2a0, 32'hff); settle; check("pending", irq_req, 17'h1);
    flags <= '0; apb(1, 32'h280, 32'h400); settle; check("soft set", irq_req, 17'h400);
    apb(0, 32'h284, 0);
    check("raw word", rd, 32'h400);
    apb(0, 32'h288, 0);
    check("req word", rd, 32'h400);
    // A write without the low strobe must leave the enables untouched
    pstrb <= 4'h0;
    apb(1, 32'h2a0, 32'h0);
    pstrb <= 4'h1;
    apb(0, 32'h2a0, 0);
    check("strobe off", rd, 32'hff);
    apb(1, 32'h280, 32'h0); settle;
    check("soft clear", irq_req, 0);
    check("soft clear any", irq_any, 0);
    apb(0, 32'h2a4, 0); check("bad addr err", er, 1); check("bad addr data", rd, 0);
    $display("awkward cases done");
    rst <= 1'b1; settle; rst <= 1'b0;
    apb(0, 32'h2a0, 0); check("reset again", rd, 0);
    settle; check("req after reset", irq_req, 0);
    $display("reset test done");
    report_and_stop;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
endmodule // interrupt_enable_gating_bench
